// File: design/vfsc_consts.vh
// Constants of the video front end serial control block
`ifndef VFSC_CONSTS_VH
`define VFSC_CONSTS_VH
`define VFSC_WORD_BITS 8
`define VFSC_STANDBY_POS 7
`define VFSC_GAIN_MSB 6
`define VFSC_GAIN_LSB 2
`define VFSC_SEL_MSB 1
`define VFSC_SEL_LSB 0
`define VFSC_WORD_RESET 8'h00
`define VFSC_SYNC_STAGES 2
`define VFSC_SCLK_IDLE 1'h0
`define VFSC_LOAD_IDLE 1'h1
`define VFSC_CASCADE_RESET 1'h0
`endif

// File: design/vfsc_serial_control.v
// Serial control port of a video front end: shift, load and cascade
`timescale 1ns/1ps
`include "vfsc_consts.vh"
module vfsc_serial_control (
  clock,
  reset_n,
  clock_enable,
  serial_clock,
  load_enable_n,
  serial_in,
  power_down_pin,
  hold_in,
  serial_out,
  standby,
  gain_code,
  input_select,
  hold_sample,
  control_word
);
  parameter WORD_BITS = `VFSC_WORD_BITS;
  input wire clock;
  input wire reset_n;
  input wire clock_enable;
  input wire serial_clock;
  input wire load_enable_n;
  input wire serial_in;
  input wire power_down_pin;
  input wire hold_in;
  output reg serial_out;
  output wire standby;
  output wire [4:0] gain_code;
  output wire [1:0] input_select;
  output wire hold_sample;
  output wire [WORD_BITS-1:0] control_word;

  // ==========================================================
  // Field positions
  localparam STANDBY_POS = `VFSC_STANDBY_POS;
  localparam GAIN_MSB = `VFSC_GAIN_MSB;
  localparam GAIN_LSB = `VFSC_GAIN_LSB;
  localparam SEL_MSB = `VFSC_SEL_MSB;
  localparam SEL_LSB = `VFSC_SEL_LSB;
  // Index of the stage that feeds the cascade output
  localparam TOP_STAGE = WORD_BITS - 1;

  // ==========================================================
  // Input synchronisers
  // Every pin but clock_enable and reset_n runs off its own timing, so each passes two flops
  // before any logic reads it; this costs two cycles of latency.
  // A low clock enable freezes these flops too, so pin edges that
  // come and go while frozen are lost.
  wire sclk_sync;
  wire load_n_sync;
  wire load_sync_inv;
  wire data_in_sync;
  wire power_down_sync;
  wire hold_sync;

  vfsc_sync u_sync_sclk (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .async_in(serial_clock),
    .sync_out(sclk_sync)
  );

  // Enable resets to idle-high through an inverted path, so that
  // reset release is not mistaken for a load edge.
  vfsc_sync u_sync_load (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .async_in(~load_enable_n),
    .sync_out(load_sync_inv)
  );
  assign load_n_sync = ~load_sync_inv;

  vfsc_sync u_sync_data (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .async_in(serial_in),
    .sync_out(data_in_sync)
  );

  vfsc_sync u_sync_power (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .async_in(power_down_pin),
    .sync_out(power_down_sync)
  );

  vfsc_sync u_sync_hold (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .async_in(hold_in),
    .sync_out(hold_sync)
  );

  // ==========================================================
  // Edge detection on synchronised levels
  reg sclk_last_reg;
  reg sclk_last_next;
  reg load_n_last_reg;
  reg load_n_last_next;
  wire shift_allowed;
  wire sclk_rise;
  wire load_rise;

  always @* begin
    sclk_last_next = sclk_sync;
    load_n_last_next = load_n_sync;
  end

  // Last-level flops reset to the idle pin levels so that no
  // false edge follows reset.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_last_reg <= `VFSC_SCLK_IDLE;
    end else if (clock_enable) begin
      sclk_last_reg <= sclk_last_next;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      load_n_last_reg <= `VFSC_LOAD_IDLE;
    end else if (clock_enable) begin
      load_n_last_reg <= load_n_last_next;
    end
  end

  // Both paths have equal latency, so the data seen with an
  // edge is the data that stood at the pin with that edge.
  assign shift_allowed = ~load_n_sync;
  assign sclk_rise = sclk_sync & ~sclk_last_reg & shift_allowed;
  assign load_rise = load_n_sync & ~load_n_last_reg;

  // ==========================================================
  // Shift register and cascade output
  reg [WORD_BITS-1:0] shift_reg;
  reg [WORD_BITS-1:0] shift_next;
  reg serial_out_next;

  always @* begin
    shift_next = shift_reg;
    serial_out_next = serial_out;
    if (sclk_rise) begin
      // First bit in travels toward the top stage
      shift_next = {shift_reg[TOP_STAGE-1:0], data_in_sync};
      // The top stage leaves as the new bit enters, so the next chip
      // sees the stream eight rises later.
      serial_out_next = shift_reg[TOP_STAGE];
    end
  end

  // The pin has no reset; reset here only gives a defined start.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= `VFSC_WORD_RESET;
      serial_out <= `VFSC_CASCADE_RESET;
    end else if (clock_enable) begin
      shift_reg <= shift_next;
      serial_out <= serial_out_next;
    end
  end

  // ==========================================================
  // Active control word
  reg [WORD_BITS-1:0] word_reg;
  reg [WORD_BITS-1:0] word_next;

  always @* begin
    word_next = word_reg;
    // A load with no rises since the last one copies the unchanged
    // shift register, so the word keeps its value.
    if (load_rise) begin
      word_next = shift_reg;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      word_reg <= `VFSC_WORD_RESET;
    end else if (clock_enable) begin
      word_reg <= word_next;
    end
  end

  // ==========================================================
  // Decoded control outputs
  wire standby_from_word;
  wire standby_from_pin;

  assign control_word = word_reg;
  assign gain_code = word_reg[GAIN_MSB:GAIN_LSB];
  assign input_select = word_reg[SEL_MSB:SEL_LSB];
  assign standby_from_word = word_reg[STANDBY_POS];
  assign standby_from_pin = power_down_sync;
  // Either source alone is enough; the pin never alters the word.
  assign standby = standby_from_word | standby_from_pin;

  // Hold pulse is passed through for the analog sample path
  assign hold_sample = hold_sync;
endmodule

// File: design/vfsc_sync.v
// Two-stage synchroniser for one asynchronous input level
`timescale 1ns/1ps
module vfsc_sync (
  clock,
  reset_n,
  clock_enable,
  async_in,
  sync_out
);
  input wire clock;
  input wire reset_n;
  input wire clock_enable;
  input wire async_in;
  output wire sync_out;

  reg meta_reg;
  reg sync_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (clock_enable) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// File: verif/vfsc_ctrl_model.sv
// Controller model
`timescale 1ns/1ps
module vfsc_ctrl_model (
  output logic serial_clock = 1'h0,
  output logic load_enable_n = 1'h1,
  output logic serial_in = 1'h0
);
  task automatic send(input [15:0] w, int n, bit en);
    load_enable_n <= !en;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= w[i];
      #100 serial_clock <= 1'h1;
      #100 serial_clock <= 1'h0;
    end
    #100 load_enable_n <= 1'h1;
    // Released line must not keep its last bit
    serial_in <= !serial_in;
    #200;
  endtask
endmodule

// File: verif/vfsc_serial_control_properties.sv
// Port checker
`timescale 1ns/1ps
module vfsc_properties (
  input clock, reset_n, serial_clock, load_enable_n, power_down_pin,
  input serial_out, standby,
  input [4:0] gain_code,
  input [1:0] input_select,
  input [7:0] control_word
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_gain_map: assert property (gain_code == control_word[6:2])
    else $error("gain");
  a_sel_map: assert property (input_select == control_word[1:0])
    else $error("sel");
  a_bit_standby: assert property (control_word[7] |-> standby)
    else $error("bit");
  a_pin_standby: assert property (power_down_pin[*3] |-> standby)
    else $error("pin");
  a_load_gate: assert property (
    $changed(control_word) |-> load_enable_n) else $error("load");
  a_word_hold: assert property (
    (!load_enable_n)[*8] |-> $stable(control_word)) else $error("hold");
  a_shift_gate: assert property (
    $changed(serial_out) |-> !load_enable_n) else $error("gate");
  a_shift_edge: assert property (
    (!serial_clock)[*6] |-> $stable(serial_out)) else $error("edge");
  cover property ($rose(standby));
  cover property ($changed(serial_out));
  cover property ($changed(control_word));
endmodule
bind vfsc_serial_control vfsc_properties vfsc_properties_inst (.*);

// File: verif/vfsc_serial_control_tb.sv
// Bench of the serial control port
`timescale 1ns/1ps
module vfsc_serial_control_tb;
  logic clock, reset_n, clock_enable, hold_in, power_down_pin, serial_out;
  logic serial_clock, load_enable_n, serial_in, standby, hold_sample;
  logic [4:0] gain_code;
  logic [1:0] input_select;
  logic [7:0] control_word, w;
  int n_mismatch, num_checks;
  vfsc_ctrl_model ctrl (.*);
  vfsc_serial_control vfsc_serial_control_inst (.*);
  task check(logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t value %h", $time, got);
    end
  endtask
  task give_verdict;
    $display("%0d checks %0d bad", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'h0;
    forever #12.5 clock = !clock;
  end
  initial begin
    #100000 n_mismatch++;
    give_verdict;
  end
  initial begin
    {reset_n, clock_enable, hold_in, power_down_pin} = 4'h4;
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    // Leading byte falls out at the cascade output
    for (w = 8'h80; w != 8'h84; w = w + 8'h41) begin
      ctrl.send({~w, w}, 16, 1'h1);
      repeat (8) @(posedge clock);
      check(control_word, w);
      check(gain_code, w[6:2]);
      check(input_select, w[1:0]);
      check(standby, w[7]);
      check(serial_out, !w[0]);
    end
    $display("load test done");
    ctrl.send(16'hFF, 8, 1'h0);
    ctrl.send(16'h0, 0, 1'h1);
    power_down_pin <= 1'h1;
    repeat (8) @(posedge clock);
    check(control_word, 8'h43);
    check(standby, 1'h1);
    $display("refuse and power down test done");
    hold_in <= 1'h1;
    repeat (4) @(posedge clock);
    check(hold_sample, 1'h1);
    hold_in <= 1'h0;
    repeat (4) @(posedge clock);
    check(hold_sample, 1'h0);
    $display("hold test done");
    give_verdict;
  end
endmodule
